/* File: bench/bst_decode_properties.sv */
`timescale 1ns/1ps
module bst_decode_chk
    import bst_pkg::*;
(
    // Instruction side
    input wire logic     aclk,
    input wire logic     aresetn,
    input wire logic     instr_valid,
    input wire logic     instr_ready,
    input wire logic     done,
    input wire logic     redirect,
    input wire logic     exc_valid,
    input wire logic     tlb_req,
    input wire bst_tlb_t tlb_kind,
    input wire logic     tlb_resp_valid,
    // Register bus
    input wire logic     s_axi_bvalid,
    input wire logic     s_axi_bready,
    input wire logic     s_axi_rvalid,
    input wire logic     s_axi_rready,
    input wire logic     s_axi_arready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_fetch;
        done && tlb_req && (tlb_kind == BST_TLB_READ || tlb_kind == BST_TLB_SEARCH);
    endsequence
    property p_done; instr_valid && instr_ready |=> done; endproperty
    property p_quiet; !(instr_valid && instr_ready) |=> !done; endproperty
    property p_tlb; s_fetch |-> !instr_ready; endproperty
    property p_wait; !instr_ready && !tlb_resp_valid |=> !instr_ready; endproperty
    property p_back; !instr_ready && tlb_resp_valid |=> instr_ready; endproperty
    property p_exc; exc_valid |-> done && !redirect && !tlb_req; endproperty
    property p_redir; redirect |-> done; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_done: assert property (p_done) else $error("no done after accept");
    a_quiet: assert property (p_quiet) else $error("done without accept");
    a_tlb: assert property (p_tlb) else $error("ready during fetch");
    a_wait: assert property (p_wait) else $error("ready before answer");
    a_back: assert property (p_back) else $error("ready not back");
    a_exc: assert property (p_exc) else $error("fault made side pulse");
    a_redir: assert property (p_redir) else $error("stray redirect");
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    a_arblk: assert property (p_arblk) else $error("arready while rvalid");
endmodule : bst_decode_chk

/* File: bench/bst_tlb_model.sv */
`timescale 1ns/1ps
module bst_tlb_model
    import bst_pkg::*;
(
    // Requests and answers
    input wire logic     aclk,
    input wire logic     tlb_req,
    input wire bst_tlb_t tlb_kind,
    output logic         tlb_resp_valid,
    output logic [31:0]  tlb_rd0,
    output logic [31:0]  tlb_rd1,
    output logic [31:0]  tlb_rd2
);
    logic [3:0] cnt_q = 4'h0;
    // Slow answer; data lines churn outside it so stale values cannot pass
    always @(posedge aclk) begin
        cnt_q <= (tlb_req && tlb_kind inside {BST_TLB_READ, BST_TLB_SEARCH}) ? 4'h4 : cnt_q - (cnt_q != 4'h0);
    end
    assign tlb_resp_valid = (cnt_q == 4'h1);
    assign tlb_rd0 = tlb_resp_valid ? 32'hA5C3_0001 : ~{8{cnt_q}};
    assign tlb_rd1 = tlb_resp_valid ? 32'h0000_0002 : {8{cnt_q}};
    assign tlb_rd2 = tlb_resp_valid ? 32'h0000_0003 : ~{8{cnt_q}};
endmodule : bst_tlb_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`include "bst_map.svh"
module testbench
    import bst_pkg::*;
;
    logic aclk = 0, aresetn = 0, instr_valid = 0, user_mode = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, instr_ready, done, redirect, exc_valid;
    logic ret_valid, external_interrupt_enable, sync_valid, resv_load, cond_store, cache_valid, spr_rd, spr_wr;
    logic tlb_req, tlb_resp_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] instr = 0, instr_pc = 0, op_a = 0, op_b = 0, s_axi_wdata = 0, redirect_target, mem_addr, cr, e;
    logic [31:0] spr_wdata, tlb_va, tlb_wr0, tlb_wr1, tlb_wr2, tlb_rd0, tlb_rd1, tlb_rd2, s_axi_rdata;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [9:0]  spr_num;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    bst_exc_t    exc_cause;
    bst_ret_t    ret_kind;
    bst_sync_t   sync_kind;
    bst_cache_t  cache_kind;
    bst_tlb_t    tlb_kind;
    integer      n_mismatch = 0, checks_done = 0, seed = 79450, k, b, ctr;
    always #2.5 aclk = ~aclk;
    bst_decode uut (.*);
    bst_tlb_model u_tlb (.*);
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task lim(input integer n);
        if (n >= 50) begin
            n_mismatch++;
            end_of_test;
        end
    endtask : lim
    function automatic logic [31:0] xf(input logic [9:0] xo, input logic [5:0] p = `BST_OP_X);
        return {p, 15'h0, xo, 1'b0};
    endfunction : xf
    task op(input logic [31:0] i, input logic [31:0] a = 0, input logic u = 0);
        integer n;
        @(posedge aclk);
        {instr, op_a, user_mode, instr_valid} <= {i, a, u, 1'b1};
        n = 0;
        do @(posedge aclk); while (instr_ready !== 1'b1 && ++n < 50);
        instr_valid <= 1'b0;
        #1;
        lim(n);
    endtask : op
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        integer n;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && ++n < 50);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
        lim(n);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
        integer n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && ++n < 50);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, x);
        chk(s_axi_rresp, r);
        lim(n);
    endtask : rd
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`BST_REG_STATUS, 0, `BST_RESP_OK);
        wr(8'h1C, 1, `BST_RESP_ERR);
        rd(8'h1C, 0, `BST_RESP_ERR);
        for (k = 0; k < 6; k++) begin
            cr = $random(seed);
            b = {$random(seed)} % 32;
            wr(`BST_REG_COND, cr, `BST_RESP_OK);
            op({`BST_OP_BC, 5'h0C, b[4:0], 16'h0});
            chk(redirect, cr[31 - b]);
            op({`BST_OP_BC, 5'h04, b[4:0], 16'h0});
            chk(redirect, !cr[31 - b]);
        end
        $display("test branch done");
        op({`BST_OP_XL, 15'h0022, `BST_XL_CRXOR, 1'b0});
        e = {cr[30] ^ cr[29], cr[30:0]};
        rd(`BST_REG_COND, e, `BST_RESP_OK);
        ctr = 2;
        wr(`BST_REG_LOOP, ctr, `BST_RESP_OK);
        repeat (2) begin
            op({`BST_OP_BC, `BST_BO_LOOP, 21'h0});
            ctr--;
            chk(redirect, ctr != 0);
        end
        rd(`BST_REG_LOOP, ctr, `BST_RESP_OK);
        for (k = 5; k < 7; k++) begin
            op({`BST_OP_TWI, 10'h080, 16'h0005}, k, 0);
            chk(exc_valid, k == 5);
            op({`BST_OP_SC, 26'h2}, 0, k[0]);
            chk({exc_valid, exc_cause}, {1'b1, BST_EXC_SYSCALL});
        end
        op(xf(`BST_XL_RFI, `BST_OP_XL), 0, 1);
        chk(exc_cause, BST_EXC_PRIV);
        op(xf(`BST_XL_RFI, `BST_OP_XL));
        chk({ret_valid, ret_kind}, {1'b1, BST_RET_STD});
        op(xf(`BST_XL_RFCI, `BST_OP_XL));
        chk({ret_valid, ret_kind}, {1'b1, BST_RET_CRIT});
        op(xf(`BST_XL_RFMCI, `BST_OP_XL));
        chk({ret_valid, ret_kind}, {1'b1, BST_RET_MCHK});
        op(xf(`BST_XL_ISYNC, `BST_OP_XL));
        chk({sync_valid, sync_kind}, {1'b1, BST_SYNC_INSTR});
        op(xf(`BST_X_MSYNC));
        chk({sync_valid, sync_kind}, {1'b1, BST_SYNC_MEM});
        op(xf(`BST_X_MBAR));
        chk({sync_valid, sync_kind}, {1'b1, BST_SYNC_BAR});
        op(xf(`BST_X_LWARX), 7);
        chk({resv_load, mem_addr[30:0]}, {1'b1, 31'h7});
        op(xf(`BST_X_ICBLC));
        chk({cache_valid, cache_kind}, {1'b1, BST_CACHE_ICLR});
        op(xf(`BST_X_DCBTSTLS));
        chk({cache_valid, cache_kind}, {1'b1, BST_CACHE_DSTLOCK});
        op(xf(`BST_X_MFSR));
        chk({exc_valid, exc_cause}, {1'b1, BST_EXC_ILLEGAL});
        op(xf(`BST_X_WRITE_IRQ_ENABLE_BIT_IMM) | 32'h8000);
        rd(`BST_REG_MSTATE, 32'h8000, `BST_RESP_OK);
        op({`BST_OP_X, 10'h01C, 5'h08, `BST_X_MFSPR, 1'b0}, 0, 1);
        chk(exc_cause, BST_EXC_PRIV);
        op({`BST_OP_X, 10'h01C, 5'h08, `BST_X_MFSPR, 1'b0});
        chk({spr_rd, spr_num}, {1'b1, 10'h11C});
        op(xf(`BST_X_TLBSX));
        chk({tlb_req, tlb_kind}, {1'b1, BST_TLB_SEARCH});
        op(xf(`BST_X_TLBRE));
        chk({tlb_req, tlb_kind}, {1'b1, BST_TLB_READ});
        op(xf(`BST_X_TLBSYNC));
        rd(`BST_REG_STG0, 32'hA5C3_0001, `BST_RESP_OK);
        $display("test control done");
        end_of_test;
    end
endmodule : testbench
bind bst_decode bst_decode_chk u_chk (.aclk, .aresetn, .instr_valid, .instr_ready, .done, .redirect, .exc_valid,
    .tlb_req, .tlb_kind, .tlb_resp_valid, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_arready);

/* File: design/bst_decode.sv */
`timescale 1ns/1ps
`include "bst_map.svh"
module bst_decode
    import bst_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Instruction issue
    input  wire logic        instr_valid,
    output logic             instr_ready,
    input  wire logic [31:0] instr,
    input  wire logic [31:0] instr_pc,
    input  wire logic [31:0] op_a,
    input  wire logic [31:0] op_b,
    input  wire logic        user_mode,
    // Completion and flow
    output logic             done,
    output logic             redirect,
    output logic [31:0]      redirect_target,
    output logic             exc_valid,
    output bst_exc_t         exc_cause,
    output logic             ret_valid,
    output bst_ret_t         ret_kind,
    output logic             external_interrupt_enable,
    // Memory ordering and atomics
    output logic             sync_valid,
    output bst_sync_t        sync_kind,
    output logic             resv_load,
    output logic             cond_store,
    output logic [31:0]      mem_addr,
    // Cache lock operations
    output logic             cache_valid,
    output bst_cache_t       cache_kind,
    // Special register moves
    output logic             spr_rd,
    output logic             spr_wr,
    output logic [9:0]       spr_num,
    output logic [31:0]      spr_wdata,
    // Translation buffer
    output logic             tlb_req,
    output bst_tlb_t         tlb_kind,
    output logic [31:0]      tlb_va,
    output logic [31:0]      tlb_wr0,
    output logic [31:0]      tlb_wr1,
    output logic [31:0]      tlb_wr2,
    input  wire logic        tlb_resp_valid,
    input  wire logic [31:0] tlb_rd0,
    input  wire logic [31:0] tlb_rd1,
    input  wire logic [31:0] tlb_rd2,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    function automatic logic cr_bit(input logic [31:0] cr, input logic [4:0] idx);
        cr_bit = cr[5'h1F - idx];
    endfunction : cr_bit

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        merge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
                 be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction : merge

    // Signed and unsigned compares tested by trap option bits, msb first
    function automatic logic trap_hit(input logic [4:0] to, input logic [31:0] a, input logic [31:0] b);
        trap_hit = (to[4] & ($signed(a) < $signed(b))) | (to[3] & ($signed(a) > $signed(b)))
                 | (to[2] & (a == b)) | (to[1] & (a < b)) | (to[0] & (a > b));
    endfunction : trap_hit

    bst_state_t  state_q, state_d;
    logic [31:0] condition_reg_q, loop_count_reg_q, stg0_q, stg1_q, stg2_q;
    logic        ee_q;
    bst_exc_t    last_exc_q;

    // Field extraction
    wire [5:0]  opc    = instr[31:26];
    wire [9:0]  xo     = instr[10:1];
    wire [4:0]  bo     = instr[25:21];
    wire [4:0]  bi     = instr[20:16];
    wire [4:0]  bb     = instr[15:11];
    wire [9:0]  sprf   = {instr[15:11], instr[20:16]};
    wire [31:0] simm   = {{16{instr[15]}}, instr[15:0]};
    wire [31:0] bdisp  = {{16{instr[15]}}, instr[15:2], 2'b00};
    wire [31:0] ea     = op_a + op_b;
    wire        accept = instr_valid & instr_ready;
    wire        is_xl  = opc == `BST_OP_XL;
    wire        is_x   = opc == `BST_OP_X;

    // Instruction classes
    wire d_bc     = opc == `BST_OP_BC;
    wire d_sc     = opc == `BST_OP_SC;
    wire d_twi    = opc == `BST_OP_TWI;
    wire d_tw     = is_x & (xo == `BST_X_TW);
    wire d_rfi    = is_xl & (xo == `BST_XL_RFI);
    wire d_rfci   = is_xl & (xo == `BST_XL_RFCI);
    wire d_rfmci  = is_xl & (xo == `BST_XL_RFMCI);
    wire d_isync  = is_xl & (xo == `BST_XL_ISYNC);
    wire d_crand  = is_xl & (xo == `BST_XL_CRAND);
    wire d_cror   = is_xl & (xo == `BST_XL_CROR);
    wire d_crxor  = is_xl & (xo == `BST_XL_CRXOR);
    wire d_crnand = is_xl & (xo == `BST_XL_CRNAND);
    wire d_crnor  = is_xl & (xo == `BST_XL_CRNOR);
    wire d_creqv  = is_xl & (xo == `BST_XL_CREQV);
    wire d_crandc = is_xl & (xo == `BST_XL_CRANDC);
    wire d_crorc  = is_xl & (xo == `BST_XL_CRORC);
    wire d_crlog  = d_crand | d_cror | d_crxor | d_crnand | d_crnor | d_creqv | d_crandc | d_crorc;
    wire d_lwarx  = is_x & (xo == `BST_X_LWARX);
    wire d_stwcx  = is_x & (xo == `BST_X_STWCX) & instr[0];
    wire d_msync  = is_x & (xo == `BST_X_MSYNC);
    wire d_mbar   = is_x & (xo == `BST_X_MBAR);
    wire d_wrtee  = is_x & (xo == `BST_X_WRTEE);
    wire d_write_irq_enable_bit_imm = is_x & (xo == `BST_X_WRITE_IRQ_ENABLE_BIT_IMM);
    wire d_mfspr  = is_x & (xo == `BST_X_MFSPR);
    wire d_mtspr  = is_x & (xo == `BST_X_MTSPR);
    wire d_icblc  = is_x & (xo == `BST_X_ICBLC);
    wire d_dcblc  = is_x & (xo == `BST_X_DCBLC);
    wire d_icbtls = is_x & (xo == `BST_X_ICBTLS);
    wire d_dcbtls = is_x & (xo == `BST_X_DCBTLS);
    wire d_dcbtst = is_x & (xo == `BST_X_DCBTSTLS);
    wire d_tlbwe  = is_x & (xo == `BST_X_TLBWE);
    wire d_tlbre  = is_x & (xo == `BST_X_TLBRE);
    wire d_tlbsx  = is_x & (xo == `BST_X_TLBSX);
    wire d_tlbie  = is_x & (xo == `BST_X_TLBIE);
    wire d_tlbsyn = is_x & (xo == `BST_X_TLBSYNC);
    wire d_cache  = d_icblc | d_dcblc | d_icbtls | d_dcbtls | d_dcbtst;
    wire d_tlb    = d_tlbwe | d_tlbre | d_tlbsx | d_tlbie;

    // Segment and direct translation-load opcodes fall through to illegal
    wire d_known = d_bc | d_sc | d_twi | d_tw | d_rfi | d_rfci | d_rfmci | d_isync | d_crlog
                 | d_lwarx | d_stwcx | d_msync | d_mbar | d_wrtee | d_write_irq_enable_bit_imm | d_mfspr | d_mtspr
                 | d_cache | d_tlb | d_tlbsyn;

    // Special register number space: bit 4 marks supervisor numbers
    wire spr_supv = sprf[`BST_SPR_SUPV_BIT];
    wire spr_ro_u = (sprf == `BST_SPR_TBL_U) | (sprf == `BST_SPR_TBU_U) | (sprf[9:2] == `BST_SPR_SH_U >> 2);
    wire spr_bad  = d_mtspr & spr_ro_u;
    wire d_priv   = d_rfi | d_rfci | d_rfmci | d_wrtee | d_write_irq_enable_bit_imm | d_cache | d_tlb | d_tlbsyn
                  | ((d_mfspr | d_mtspr) & spr_supv);

    // Branch evaluation
    wire [31:0] ctr_dec = loop_count_reg_q - 32'h1;
    wire        bc_dec  = d_bc & ~bo[2];
    wire        ctr_ok  = bo[2] | ((ctr_dec != 32'h0) ^ bo[1]);
    wire        cond_ok = bo[4] | (cr_bit(condition_reg_q, bi) == bo[3]);
    wire        bc_take = ctr_ok & cond_ok;
    wire [31:0] bc_tgt  = instr[1] ? bdisp : instr_pc + bdisp;

    // Condition-register logic
    wire ca = cr_bit(condition_reg_q, bi);
    wire cb = cr_bit(condition_reg_q, bb);
    wire cr_res = d_crand ? (ca & cb) : d_cror ? (ca | cb) : d_crxor ? (ca ^ cb)
                : d_crnand ? ~(ca & cb) : d_crnor ? ~(ca | cb) : d_creqv ? ~(ca ^ cb)
                : d_crandc ? (ca & ~cb) : (ca | ~cb);

    wire trap_t = (d_tw & trap_hit(bo, op_a, op_b)) | (d_twi & trap_hit(bo, op_a, simm));

    wire fault_ill  = ~d_known | spr_bad;
    wire fault_priv = d_known & ~spr_bad & d_priv & user_mode;
    wire ok         = ~fault_ill & ~fault_priv;
    wire exc_now    = fault_ill | fault_priv | trap_t | d_sc;
    wire bst_exc_t  exc_sel = fault_ill ? BST_EXC_ILLEGAL : fault_priv ? BST_EXC_PRIV
                            : d_sc ? BST_EXC_SYSCALL : BST_EXC_TRAP;
    wire        tlb_wait = ok & (d_tlbre | d_tlbsx);

    // AXI4-Lite slave
    logic        aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;
    wire wr_go  = aw_have_q & w_have_q & ~bvalid_q;
    wire wr_map = awaddr_q <= `BST_REG_STATUS;
    wire rd_go  = s_axi_arvalid & ~rvalid_q;
    wire rd_map = s_axi_araddr <= `BST_REG_STATUS;
    wire we_cr  = wr_go & (awaddr_q == `BST_REG_COND);
    wire we_ctr = wr_go & (awaddr_q == `BST_REG_LOOP);
    wire we_ms  = wr_go & (awaddr_q == `BST_REG_MSTATE);
    wire we_s0  = wr_go & (awaddr_q == `BST_REG_STG0);
    wire we_s1  = wr_go & (awaddr_q == `BST_REG_STG1);
    wire we_s2  = wr_go & (awaddr_q == `BST_REG_STG2);
    wire [31:0] status_w = {27'h0, state_q == BST_ST_WAIT, 1'b0, last_exc_q};
    wire [31:0] rd_mux = (s_axi_araddr == `BST_REG_COND) ? condition_reg_q
                       : (s_axi_araddr == `BST_REG_LOOP) ? loop_count_reg_q
                       : (s_axi_araddr == `BST_REG_MSTATE) ? {16'h0, ee_q, 15'h0}
                       : (s_axi_araddr == `BST_REG_STG0) ? stg0_q
                       : (s_axi_araddr == `BST_REG_STG1) ? stg1_q
                       : (s_axi_araddr == `BST_REG_STG2) ? stg2_q
                       : (s_axi_araddr == `BST_REG_STATUS) ? status_w : `BST_RST_WORD;

    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready  = ~w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= `BST_RST_WORD;
            wstrb_q   <= 4'h0;
            bresp_q   <= `BST_RESP_OK;
        end else begin
            if (s_axi_awvalid & ~aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid & ~w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_map ? `BST_RESP_OK : `BST_RESP_ERR;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end else if (bvalid_q & s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= `BST_RST_WORD;
            rresp_q  <= `BST_RESP_OK;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_map ? `BST_RESP_OK : `BST_RESP_ERR;
        end else if (rvalid_q & s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Translation reads hold issue until the entry returns
    assign instr_ready = state_q == BST_ST_IDLE;
    always_comb begin
        case (state_q)
            BST_ST_IDLE: state_d = (accept & tlb_wait) ? BST_ST_WAIT : BST_ST_IDLE;
            BST_ST_WAIT: state_d = tlb_resp_valid ? BST_ST_IDLE : BST_ST_WAIT;
            default:     state_d = BST_ST_IDLE;
        endcase
    end

    // Instruction updates win over a same-cycle bus write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q          <= BST_ST_IDLE;
            condition_reg_q  <= `BST_RST_WORD;
            loop_count_reg_q <= `BST_RST_WORD;
            ee_q             <= 1'b0;
            last_exc_q       <= BST_EXC_NONE;
        end else begin
            state_q <= state_d;
            if (accept & ok & d_crlog)
                condition_reg_q[5'h1F - instr[25:21]] <= cr_res;
            else if (we_cr)
                condition_reg_q <= merge(condition_reg_q, wdata_q, wstrb_q);
            if (accept & ok & bc_dec)
                loop_count_reg_q <= ctr_dec;
            else if (we_ctr)
                loop_count_reg_q <= merge(loop_count_reg_q, wdata_q, wstrb_q);
            // Only the enable bit moves; no pipeline drain is requested
            if (accept & ok & d_wrtee)
                ee_q <= op_a[`BST_EE_BIT];
            else if (accept & ok & d_write_irq_enable_bit_imm)
                ee_q <= instr[`BST_EE_BIT];
            else if (we_ms & wstrb_q[1])
                ee_q <= wdata_q[`BST_EE_BIT];
            if (accept & exc_now)
                last_exc_q <= exc_sel;
        end
    end

    // Staging registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stg0_q <= `BST_RST_WORD;
            stg1_q <= `BST_RST_WORD;
            stg2_q <= `BST_RST_WORD;
        end else if (state_q == BST_ST_WAIT && tlb_resp_valid) begin
            stg0_q <= tlb_rd0;
            stg1_q <= tlb_rd1;
            stg2_q <= tlb_rd2;
        end else begin
            if (we_s0)
                stg0_q <= merge(stg0_q, wdata_q, wstrb_q);
            if (we_s1)
                stg1_q <= merge(stg1_q, wdata_q, wstrb_q);
            if (we_s2)
                stg2_q <= merge(stg2_q, wdata_q, wstrb_q);
        end
    end

    assign tlb_wr0 = stg0_q;
    assign tlb_wr1 = stg1_q;
    assign tlb_wr2 = stg2_q;
    assign external_interrupt_enable = ee_q;

    // One-cycle result pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done        <= 1'b0;
            redirect    <= 1'b0;
            exc_valid   <= 1'b0;
            ret_valid   <= 1'b0;
            sync_valid  <= 1'b0;
            resv_load   <= 1'b0;
            cond_store  <= 1'b0;
            cache_valid <= 1'b0;
            spr_rd      <= 1'b0;
            spr_wr      <= 1'b0;
            tlb_req     <= 1'b0;
        end else begin
            done        <= accept;
            redirect    <= accept & ok & d_bc & bc_take;
            exc_valid   <= accept & exc_now;
            ret_valid   <= accept & ok & (d_rfi | d_rfci | d_rfmci);
            sync_valid  <= accept & ok & (d_isync | d_msync | d_mbar | d_tlbsyn);
            resv_load   <= accept & ok & d_lwarx;
            cond_store  <= accept & ok & d_stwcx;
            cache_valid <= accept & ok & d_cache;
            spr_rd      <= accept & ok & d_mfspr;
            spr_wr      <= accept & ok & d_mtspr;
            tlb_req     <= accept & ok & d_tlb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            redirect_target <= `BST_RST_WORD;
            exc_cause       <= BST_EXC_NONE;
            ret_kind        <= BST_RET_STD;
            sync_kind       <= BST_SYNC_INSTR;
            cache_kind      <= BST_CACHE_ICLR;
            tlb_kind        <= BST_TLB_WRITE;
            mem_addr        <= `BST_RST_WORD;
            tlb_va          <= `BST_RST_WORD;
            spr_num         <= 10'h000;
            spr_wdata       <= `BST_RST_WORD;
        end else if (accept) begin
            redirect_target <= bc_tgt;
            exc_cause       <= exc_now ? exc_sel : BST_EXC_NONE;
            ret_kind        <= d_rfci ? BST_RET_CRIT : d_rfmci ? BST_RET_MCHK : BST_RET_STD;
            // Barrier uses the classic in-order I/O opcode
            sync_kind       <= d_isync ? BST_SYNC_INSTR : d_mbar ? BST_SYNC_BAR
                             : d_tlbsyn ? BST_SYNC_TLB : BST_SYNC_MEM;
            cache_kind      <= d_icblc ? BST_CACHE_ICLR : d_dcblc ? BST_CACHE_DCLR
                             : d_icbtls ? BST_CACHE_ILOCK : d_dcbtls ? BST_CACHE_DLOCK
                             : BST_CACHE_DSTLOCK;
            tlb_kind        <= d_tlbre ? BST_TLB_READ : d_tlbsx ? BST_TLB_SEARCH
                             : d_tlbie ? BST_TLB_INVAL : BST_TLB_WRITE;
            mem_addr        <= ea;
            tlb_va          <= ea;
            spr_num         <= sprf;
            spr_wdata       <= op_a;
        end
    end
endmodule : bst_decode

/* File: design/bst_map.svh */
`ifndef BST_MAP_SVH
`define BST_MAP_SVH
`define BST_OP_TWI    6'h03
`define BST_OP_BC     6'h10
`define BST_OP_SC     6'h11
`define BST_OP_XL     6'h13
`define BST_OP_X      6'h1F
`define BST_XL_RFMCI  10'h026
`define BST_XL_RFI    10'h032
`define BST_XL_RFCI   10'h033
`define BST_XL_ISYNC  10'h096
`define BST_XL_CRNOR  10'h021
`define BST_XL_CRANDC 10'h081
`define BST_XL_CRXOR  10'h0C1
`define BST_XL_CRNAND 10'h0E1
`define BST_XL_CRAND  10'h101
`define BST_XL_CREQV  10'h121
`define BST_XL_CRORC  10'h1A1
`define BST_XL_CROR   10'h1C1
`define BST_X_TW      10'h004
`define BST_X_LWARX   10'h014
`define BST_X_WRTEE   10'h083
`define BST_X_DCBTSTLS 10'h086
`define BST_X_STWCX   10'h096
`define BST_X_WRITE_IRQ_ENABLE_BIT_IMM  10'h0A3
`define BST_X_DCBTLS  10'h0A6
`define BST_X_ICBLC   10'h0E6
`define BST_X_TLBIE   10'h132
`define BST_X_MFSPR   10'h153
`define BST_X_DCBLC   10'h186
`define BST_X_MTSPR   10'h1D3
`define BST_X_ICBTLS  10'h1E6
`define BST_X_TLBSYNC 10'h236
`define BST_X_MFSR    10'h253
`define BST_X_MSYNC   10'h256
`define BST_X_MBAR    10'h356
`define BST_X_TLBSX   10'h392
`define BST_X_TLBRE   10'h3B2
`define BST_X_TLBWE   10'h3D2
`define BST_BO_LOOP   5'h10
`define BST_SPR_SUPV_BIT 4
`define BST_SPR_TBL_U 10'h10C
`define BST_SPR_TBU_U 10'h10D
`define BST_SPR_SH_U  10'h104
`define BST_REG_COND  8'h00
`define BST_REG_LOOP  8'h04
`define BST_REG_MSTATE 8'h08
`define BST_REG_STG0  8'h0C
`define BST_REG_STG1  8'h10
`define BST_REG_STG2  8'h14
`define BST_REG_STATUS 8'h18
`define BST_RST_WORD  32'h0000_0000
`define BST_RESP_OK   2'h0
`define BST_RESP_ERR  2'h2
`define BST_EE_BIT    15
`endif

/* File: design/bst_pkg.sv */
package bst_pkg;
    typedef enum logic [2:0] {
        BST_EXC_NONE = 3'h0,
        BST_EXC_TRAP = 3'h1,
        BST_EXC_SYSCALL = 3'h2,
        BST_EXC_ILLEGAL = 3'h3,
        BST_EXC_PRIV = 3'h4
    } bst_exc_t;
    typedef enum logic [1:0] {
        BST_RET_STD = 2'h0,
        BST_RET_CRIT = 2'h1,
        BST_RET_MCHK = 2'h2
    } bst_ret_t;
    typedef enum logic [1:0] {
        BST_SYNC_INSTR = 2'h0,
        BST_SYNC_MEM = 2'h1,
        BST_SYNC_BAR = 2'h2,
        BST_SYNC_TLB = 2'h3
    } bst_sync_t;
    typedef enum logic [2:0] {
        BST_CACHE_ICLR = 3'h0,
        BST_CACHE_DCLR = 3'h1,
        BST_CACHE_ILOCK = 3'h2,
        BST_CACHE_DLOCK = 3'h3,
        BST_CACHE_DSTLOCK = 3'h4
    } bst_cache_t;
    typedef enum logic [1:0] {
        BST_TLB_WRITE = 2'h0,
        BST_TLB_READ = 2'h1,
        BST_TLB_SEARCH = 2'h2,
        BST_TLB_INVAL = 2'h3
    } bst_tlb_t;
    typedef enum logic [1:0] {
        BST_ST_IDLE = 2'b01,
        BST_ST_WAIT = 2'b10
    } bst_state_t;
endpackage : bst_pkg
